// File: hw/uvs_params.svh
// register offsets, reset values, setting ranges and timing constants of the undervoltage stage
`ifndef UVS_PARAMS_SVH
`define UVS_PARAMS_SVH
`define UVS_ADDR_CTRL      8'h00
`define UVS_ADDR_PICKUP    8'h04
`define UVS_ADDR_INHIBIT   8'h08
`define UVS_ADDR_DROPOFF   8'h0C
`define UVS_ADDR_DELAY     8'h10
`define UVS_ADDR_STATUS    8'h14
`define UVS_ADDR_IRQ_STAT  8'h18
`define UVS_ADDR_IRQ_MASK  8'h1C
`define UVS_CTRL_SEL_LSB   0
`define UVS_CTRL_ONLY_BIT  2
`define UVS_CTRL_PTP_BIT   3
`define UVS_IRQ_START_BIT  0
`define UVS_IRQ_TRIP_BIT   1
`define UVS_RST_PICKUP     8'h5A
`define UVS_MIN_PICKUP     8'h1E
`define UVS_MAX_PICKUP     8'h82
`define UVS_RST_INHIBIT    8'h0A
`define UVS_MAX_INHIBIT    8'h14
`define UVS_RST_DROPOFF    8'h05
`define UVS_MIN_DROPOFF    8'h01
`define UVS_MAX_DROPOFF    8'h0A
`define UVS_RST_DELAY      16'h0064
`define UVS_MIN_DELAY      16'h0032
`define UVS_MAX_DELAY      16'hEA60
`define UVS_TICK_NS        1000000
`define UVS_CLK_NS         4
`define UVS_TICK_CYCLES    (`UVS_TICK_NS / `UVS_CLK_NS)
`endif

// File: hw/uvs_pkg.sv
// types shared by the undervoltage stage modules
package uvs_pkg;
	typedef enum logic [1:0] {UVS_OFF, UVS_ANY1, UVS_ANY2, UVS_ALL} uvs_sel_t;
	typedef struct packed
	{
		uvs_sel_t    sel;
		logic        pickup_only;
		logic        ptp;
		logic [7:0]  pickup;
		logic [7:0]  inhibit;
		logic [7:0]  dropoff;
		logic [15:0] delay;
	} uvs_cfg_t;
	typedef struct packed
	{
		logic [15:0] v1;
		logic [15:0] v2;
		logic [15:0] v3;
	} uvs_volt_t;
endpackage

// File: hw/uvs_phase.sv
// one measured voltage: start with inhibit and drop-off, trip delay counter
module uvs_phase
(
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// measurement and settings
	input  wire logic [15:0]      volt_in,
	input  wire uvs_pkg::uvs_cfg_t cfg_in,
	input  wire logic             enable_in,
	input  wire logic             inhibit_in,
	input  wire logic             tick_in,
	// results
	output logic                  start_out,
	output logic                  trip_out
);
	import uvs_pkg::*;

	logic [23:0] v_x100;
	logic [23:0] pick_x1000;
	logic [23:0] inh_x1000;
	logic [23:0] rel_x100;
	logic        below_pick;
	logic        below_inh;
	logic        above_rel;
	logic        start_r;
	logic        start_nxt;
	logic [15:0] cnt_r;
	logic        trip_r;

	// volt_in is in 0.1 % of nominal, settings in whole percent
	assign v_x100     = 24'(volt_in) * 24'd100;
	assign pick_x1000 = 24'(cfg_in.pickup) * 24'd1000;
	assign inh_x1000  = 24'(cfg_in.inhibit) * 24'd1000;
	assign rel_x100   = 24'(cfg_in.pickup) * (24'd1000 + 24'(cfg_in.dropoff) * 24'd10);
	assign below_pick = v_x100 < pick_x1000;
	assign below_inh  = v_x100 < inh_x1000;
	assign above_rel  = v_x100 >= rel_x100;

	always_comb
	begin
		if (!enable_in || inhibit_in || below_inh)
			start_nxt = 1'b0;
		else if (start_r)
			start_nxt = !above_rel;
		else
			start_nxt = below_pick;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			start_r <= 1'b0;
		else
			start_r <= start_nxt;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in || !start_r || inhibit_in)
			cnt_r <= 16'h0000;
		else if (tick_in && cnt_r < cfg_in.delay)
			cnt_r <= cnt_r + 16'h0001;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			trip_r <= 1'b0;
		else
			trip_r <= start_r && !inhibit_in && cnt_r >= cfg_in.delay;
	end

	assign start_out = start_r;
	assign trip_out  = trip_r;

	property p_inhibit;
		@(posedge clk_in) disable iff (rst_in) below_inh |=> !start_r;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("start set below inhibit level");

	property p_pickup;
		@(posedge clk_in) disable iff (rst_in)
		(!start_r && below_pick && !below_inh && enable_in && !inhibit_in) |=> start_r;
	endproperty
	a_pickup: assert property (p_pickup) else $error("start missed below pickup");

	property p_hold;
		@(posedge clk_in) disable iff (rst_in)
		(start_r && !above_rel && !below_inh && enable_in && !inhibit_in) |=> start_r;
	endproperty
	a_hold: assert property (p_hold) else $error("start released inside drop-off band");

	property p_clear;
		@(posedge clk_in) disable iff (rst_in) !start_r |=> cnt_r == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("delay count not cleared");

	property p_trip;
		@(posedge clk_in) disable iff (rst_in)
		trip_r |-> $past(start_r) && $past(cnt_r) >= $past(cfg_in.delay);
	endproperty
	a_trip: assert property (p_trip) else $error("trip before delay expired");
endmodule

// File: hw/uvs_stage.sv
// three-phase definite-time undervoltage stage with register port and interrupt
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`include "uvs_params.svh"
module uvs_stage
#(
	parameter int TICK_CYCLES = `UVS_TICK_CYCLES
)
(
	// clock and reset
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	// register port
	input  wire logic [7:0]         addr_in,
	input  wire logic [31:0]        wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	output logic      [31:0]        rdata_out,
	// measurements from the upstream stage
	input  wire uvs_pkg::uvs_volt_t phase_fundamental_in,
	input  wire uvs_pkg::uvs_volt_t line_fundamental_in,
	input  wire logic               function_inhibit_in,
	// published results
	output logic      [2:0]         pickups_out,
	output logic                    ptp_mode_out,
	output logic                    any_pickup_out,
	output logic                    combined_trip_out,
	output logic                    irq_out
);
	import uvs_pkg::*;

	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

	uvs_cfg_t    cfg_r;
	uvs_volt_t   volt_sel;
	logic [31:0] tick_cnt_r;
	logic        tick_r;
	logic [2:0]  start_vec;
	logic [2:0]  trip_vec;
	logic        enable;
	logic        gen_start_nxt;
	logic        gen_trip_nxt;
	logic [1:0]  irq_stat_r;
	logic [1:0]  irq_mask_r;
	logic [1:0]  irq_set;
	logic [31:0] rdata_nxt;

	// limit a written setting to its legal range
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
	begin
		if (v < lo)
			clamp = lo;
		else if (v > hi)
			clamp = hi;
		else
			clamp = v;
	end
	endfunction

	// k or more of three set
	function automatic logic vote(input logic [2:0] v, input uvs_sel_t sel);
		logic [1:0] n;
	begin
		n = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
		case (sel)
			UVS_ANY1: vote = n >= 2'd1;
			UVS_ANY2: vote = n >= 2'd2;
			UVS_ALL:  vote = n == 2'd3;
			default:  vote = 1'b0;
		endcase
	end
	endfunction

	// settings written by software
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cfg_r.sel         <= UVS_OFF;
			cfg_r.pickup_only <= 1'b0;
			cfg_r.ptp         <= 1'b0;
			cfg_r.pickup      <= `UVS_RST_PICKUP;
			cfg_r.inhibit     <= `UVS_RST_INHIBIT;
			cfg_r.dropoff     <= `UVS_RST_DROPOFF;
			cfg_r.delay       <= `UVS_RST_DELAY;
		end
		else if (wr_in)
		begin
			if (addr_in == `UVS_ADDR_CTRL)
			begin
				cfg_r.sel         <= uvs_sel_t'(wdata_in[`UVS_CTRL_SEL_LSB +: 2]);
				cfg_r.pickup_only <= wdata_in[`UVS_CTRL_ONLY_BIT];
				cfg_r.ptp         <= wdata_in[`UVS_CTRL_PTP_BIT];
			end
			else if (addr_in == `UVS_ADDR_PICKUP)
				cfg_r.pickup <= 8'(clamp({8'h00, wdata_in[7:0]},
					{8'h00, `UVS_MIN_PICKUP}, {8'h00, `UVS_MAX_PICKUP}));
			else if (addr_in == `UVS_ADDR_INHIBIT)
				cfg_r.inhibit <= 8'(clamp({8'h00, wdata_in[7:0]},
					16'h0000, {8'h00, `UVS_MAX_INHIBIT}));
			else if (addr_in == `UVS_ADDR_DROPOFF)
				cfg_r.dropoff <= 8'(clamp({8'h00, wdata_in[7:0]},
					{8'h00, `UVS_MIN_DROPOFF}, {8'h00, `UVS_MAX_DROPOFF}));
			else if (addr_in == `UVS_ADDR_DELAY)
				cfg_r.delay <= clamp(wdata_in[15:0], `UVS_MIN_DELAY, `UVS_MAX_DELAY);
		end
	end

	// millisecond tick
	always_ff @(posedge clk_in)
	begin
		if (rst_in || tick_cnt_r == TICK_LAST)
			tick_cnt_r <= 32'h0000_0000;
		else
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			tick_r <= 1'b0;
		else
			tick_r <= tick_cnt_r == TICK_LAST;
	end

	// phase or line-to-line magnitudes
	assign volt_sel = cfg_r.ptp ? line_fundamental_in : phase_fundamental_in;
	assign enable   = cfg_r.sel != UVS_OFF;

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_phase
			uvs_phase u_phase
			(
				.clk_in     (clk_in),
				.rst_in     (rst_in),
				.volt_in    (volt_sel[16*(2-g) +: 16]),
				.cfg_in     (cfg_r),
				.enable_in  (enable),
				.inhibit_in (function_inhibit_in),
				.tick_in    (tick_r),
				.start_out  (start_vec[g]),
				.trip_out   (trip_vec[g])
			);
		end
	endgenerate

	// decision logic
	assign gen_start_nxt = enable && !function_inhibit_in && |start_vec;
	assign gen_trip_nxt  = !cfg_r.pickup_only && !function_inhibit_in
		&& vote(trip_vec, cfg_r.sel);

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			pickups_out       <= 3'b000;
			any_pickup_out    <= 1'b0;
			combined_trip_out <= 1'b0;
			ptp_mode_out      <= 1'b0;
		end
		else
		begin
			pickups_out       <= function_inhibit_in ? 3'b000 : start_vec;
			any_pickup_out    <= gen_start_nxt;
			combined_trip_out <= gen_trip_nxt;
			ptp_mode_out      <= cfg_r.ptp;
		end
	end

	// sticky events: rising general start and trip; set wins over clear
	assign irq_set[`UVS_IRQ_START_BIT] = gen_start_nxt && !any_pickup_out;
	assign irq_set[`UVS_IRQ_TRIP_BIT]  = gen_trip_nxt && !combined_trip_out;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			irq_stat_r <= 2'b00;
		else if (wr_in && addr_in == `UVS_ADDR_IRQ_STAT)
			irq_stat_r <= (irq_stat_r & ~wdata_in[1:0]) | irq_set;
		else
			irq_stat_r <= irq_stat_r | irq_set;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			irq_mask_r <= 2'b00;
		else if (wr_in && addr_in == `UVS_ADDR_IRQ_MASK)
			irq_mask_r <= wdata_in[1:0];
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(irq_stat_r & irq_mask_r);
	end

	// read decode, unmapped reads return zero
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (addr_in == `UVS_ADDR_CTRL)
			rdata_nxt = {28'h000_0000, cfg_r.ptp, cfg_r.pickup_only, cfg_r.sel};
		else if (addr_in == `UVS_ADDR_PICKUP)
			rdata_nxt = {24'h00_0000, cfg_r.pickup};
		else if (addr_in == `UVS_ADDR_INHIBIT)
			rdata_nxt = {24'h00_0000, cfg_r.inhibit};
		else if (addr_in == `UVS_ADDR_DROPOFF)
			rdata_nxt = {24'h00_0000, cfg_r.dropoff};
		else if (addr_in == `UVS_ADDR_DELAY)
			rdata_nxt = {16'h0000, cfg_r.delay};
		else if (addr_in == `UVS_ADDR_STATUS)
			rdata_nxt = {26'h000_0000, function_inhibit_in, combined_trip_out,
				any_pickup_out, pickups_out};
		else if (addr_in == `UVS_ADDR_IRQ_STAT)
			rdata_nxt = {30'h0000_0000, irq_stat_r};
		else if (addr_in == `UVS_ADDR_IRQ_MASK)
			rdata_nxt = {30'h0000_0000, irq_mask_r};
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rdata_out <= 32'h0000_0000;
		else if (rd_in)
			rdata_out <= rdata_nxt;
		else
			rdata_out <= 32'h0000_0000;
	end

	property p_off;
		@(posedge clk_in) disable iff (rst_in)
		(cfg_r.sel == UVS_OFF) [*2] |=> pickups_out == 3'b000 && !any_pickup_out
			&& !combined_trip_out;
	endproperty
	a_off: assert property (p_off) else $error("outputs active while off");

	property p_only;
		@(posedge clk_in) disable iff (rst_in) cfg_r.pickup_only |=> !combined_trip_out;
	endproperty
	a_only: assert property (p_only) else $error("trip in pickup-only mode");

	property p_block;
		@(posedge clk_in) disable iff (rst_in)
		function_inhibit_in [*2] |=> pickups_out == 3'b000 && !any_pickup_out
			&& !combined_trip_out;
	endproperty
	a_block: assert property (p_block) else $error("output active while inhibited");

	property p_gen_start;
		@(posedge clk_in) disable iff (rst_in)
		(enable && |start_vec && !function_inhibit_in) |=> any_pickup_out;
	endproperty
	a_gen_start: assert property (p_gen_start) else $error("general start missing");

	property p_all;
		@(posedge clk_in) disable iff (rst_in)
		(cfg_r.sel == UVS_ALL && trip_vec != 3'b111) |=> !combined_trip_out;
	endproperty
	a_all: assert property (p_all) else $error("all-phase trip with a phase missing");

	property p_any2;
		@(posedge clk_in) disable iff (rst_in)
		(cfg_r.sel == UVS_ANY2 && trip_vec == 3'b011 && !cfg_r.pickup_only
			&& !function_inhibit_in) |=> combined_trip_out;
	endproperty
	a_any2: assert property (p_any2) else $error("two-phase trip missing");

	property p_irq;
		@(posedge clk_in) disable iff (rst_in)
		$rose(combined_trip_out) |-> irq_stat_r[`UVS_IRQ_TRIP_BIT];
	endproperty
	a_irq: assert property (p_irq) else $error("trip event not recorded");

	// a pending unmasked event raises the level one cycle later
	property p_irq_level;
		@(posedge clk_in) disable iff (rst_in) (|(irq_stat_r & irq_mask_r)) |=> irq_out;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level missing");

	property p_ptp;
		@(posedge clk_in) disable iff (rst_in) cfg_r.ptp |=> ptp_mode_out;
	endproperty
	a_ptp: assert property (p_ptp) else $error("pair mode flag missing");

	c_start: cover property (@(posedge clk_in) disable iff (rst_in) $rose(any_pickup_out));
	c_all:   cover property (@(posedge clk_in) disable iff (rst_in)
		cfg_r.sel == UVS_ALL && combined_trip_out);
	c_trip:  cover property (@(posedge clk_in) disable iff (rst_in) $rose(combined_trip_out));
	c_irq:   cover property (@(posedge clk_in) disable iff (rst_in) $rose(irq_out));
endmodule

// File: tb/uvs_source.sv
// upstream magnitude source and user block logic facing the stage
module uvs_source
(
	// clock
	input  wire logic          clk_in,
	// magnitudes and block input
	output uvs_pkg::uvs_volt_t phase_out,
	output uvs_pkg::uvs_volt_t line_out,
	output logic               inhibit_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import uvs_pkg::*;

	initial
	begin
		phase_out = {3{16'h03E8}};
		line_out = {3{16'h03E8}};
		inhibit_out = 1'b0;
	end

	// all magnitudes and the block input change together just after an edge
	task automatic drive(input uvs_volt_t ph, input uvs_volt_t ln, input logic blk);
		@(posedge clk_in);
		phase_out <= ph;
		line_out <= ln;
		inhibit_out <= blk;
	endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench of the undervoltage stage
`include "uvs_params.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import uvs_pkg::*;

	localparam int          TC = 10;
	localparam logic [15:0] N  = 16'h03E8;
	localparam logic [15:0] L  = 16'h0320;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [31:0] rdata_out;
	uvs_volt_t   ph;
	uvs_volt_t   ln;
	logic        blk;
	logic [2:0]  pickups_out;
	logic        ptp_mode_out;
	logic        any_pickup_out;
	logic        combined_trip_out;
	logic        irq_out;
	logic [31:0] d;
	int          errors = 0;
	int          n_compared = 0;
	int          cyc = 0;

	uvs_stage #(.TICK_CYCLES(TC)) u_uvs_stage
	(
		.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.phase_fundamental_in(ph), .line_fundamental_in(ln), .function_inhibit_in(blk),
		.pickups_out(pickups_out), .ptp_mode_out(ptp_mode_out),
		.any_pickup_out(any_pickup_out), .combined_trip_out(combined_trip_out),
		.irq_out(irq_out)
	);
	uvs_source u_uvs_source
	(
		.clk_in(clk_in), .phase_out(ph), .line_out(ln), .inhibit_out(blk)
	);

	always #2 clk_in = ~clk_in;

	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= v;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	// read data is only valid in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
		check($sformatf("register %h", a), d, exp);
	endtask

	task automatic oc(input logic [4:0] e);
		check("outputs", {27'h0, pickups_out, any_pickup_out, combined_trip_out}, {27'h0, e});
	endtask

	task automatic dv(input uvs_volt_t p, input uvs_volt_t q, input logic b);
		u_uvs_source.drive(p, q, b);
	endtask

	// n phases low under a selector; trip expected or not after the delay
	task automatic run(input logic [31:0] c, input int n, input logic e);
		logic [2:0] pk;
		pk = 3'((1 << n) - 1);
		dv({3{N}}, {3{N}}, 1'b0);
		wr(`UVS_ADDR_CTRL, c);
		waitc(3);
		dv({L, n > 1 ? L : N, n > 2 ? L : N}, {3{N}}, 1'b0);
		waitc(485);
		oc({pk, 2'b10});
		waitc(30);
		check("trip", {31'h0, combined_trip_out}, {31'h0, e});
	endtask

	initial
	begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		rchk(`UVS_ADDR_CTRL, 32'h0000_0000);
		rchk(`UVS_ADDR_PICKUP, 32'h0000_005A);
		rchk(`UVS_ADDR_INHIBIT, 32'h0000_000A);
		rchk(`UVS_ADDR_DROPOFF, 32'h0000_0005);
		rchk(`UVS_ADDR_DELAY, 32'h0000_0064);
		rchk(8'h20, 32'h0000_0000);
		wr(`UVS_ADDR_PICKUP, 32'h0000_00C8);
		rchk(`UVS_ADDR_PICKUP, 32'h0000_0082);
		wr(`UVS_ADDR_DELAY, 32'h0000_000A);
		rchk(`UVS_ADDR_DELAY, 32'h0000_0032);
		wr(`UVS_ADDR_INHIBIT, 32'h0000_00FF);
		rchk(`UVS_ADDR_INHIBIT, 32'h0000_0014);
		wr(`UVS_ADDR_DROPOFF, 32'h0000_0000);
		rchk(`UVS_ADDR_DROPOFF, 32'h0000_0001);
		wr(`UVS_ADDR_INHIBIT, 32'h0000_000A);
		wr(`UVS_ADDR_DROPOFF, 32'h0000_0005);
		wr(`UVS_ADDR_PICKUP, 32'h0000_005A);
		$display("test registers done");
		dv({L, N, N}, {3{N}}, 1'b0);
		waitc(3);
		oc(5'b00000);
		wr(`UVS_ADDR_IRQ_MASK, 32'h0000_0003);
		for (int s = 1; s < 4; s++)
			for (int n = 1; n < 4; n++)
				run(32'(s), n, n >= s);
		check("irq", {31'h0, irq_out}, 32'h0000_0001);
		rchk(`UVS_ADDR_IRQ_STAT, 32'h0000_0003);
		$display("test selector done");
		dv({3{L}}, {3{N}}, 1'b1);
		waitc(3);
		oc(5'b00000);
		rchk(`UVS_ADDR_STATUS, 32'h0000_0020);
		dv({3{L}}, {3{N}}, 1'b0);
		waitc(300);
		oc(5'b11110);
		wr(`UVS_ADDR_CTRL, 32'h0000_0005);
		waitc(300);
		oc(5'b11110);
		$display("test block and pickup only done");
		wr(`UVS_ADDR_CTRL, 32'h0000_0001);
		dv({16'h03AC, N, N}, {3{N}}, 1'b0);
		waitc(3);
		oc(5'b00111);
		dv({16'h03B6, N, N}, {3{N}}, 1'b0);
		waitc(3);
		oc(5'b00000);
		dv({16'h0383, N, N}, {3{N}}, 1'b0);
		waitc(3);
		oc(5'b00110);
		dv({16'h0063, N, N}, {3{N}}, 1'b0);
		waitc(3);
		oc(5'b00000);
		dv({16'h0064, N, N}, {3{N}}, 1'b0);
		waitc(3);
		oc(5'b00110);
		dv({N, N, N}, {3{N}}, 1'b0);
		dv({16'h0384, N, N}, {3{N}}, 1'b0);
		waitc(3);
		oc(5'b00000);
		$display("test levels done");
		wr(`UVS_ADDR_CTRL, 32'h0000_0009);
		dv({L, N, N}, {3{N}}, 1'b0);
		waitc(3);
		oc(5'b00000);
		check("pair mode", {31'h0, ptp_mode_out}, 32'h0000_0001);
		dv({L, N, N}, {N, L, N}, 1'b0);
		waitc(3);
		oc(5'b01010);
		wr(`UVS_ADDR_IRQ_STAT, 32'h0000_0003);
		rchk(`UVS_ADDR_IRQ_STAT, 32'h0000_0000);
		waitc(2);
		check("irq", {31'h0, irq_out}, 32'h0000_0000);
		wr(`UVS_ADDR_IRQ_MASK, 32'h0000_0000);
		dv({3{N}}, {3{N}}, 1'b0);
		dv({3{N}}, {L, N, N}, 1'b0);
		waitc(3);
		rchk(`UVS_ADDR_IRQ_STAT, 32'h0000_0001);
		check("irq", {31'h0, irq_out}, 32'h0000_0000);
		$display("test pairs and interrupt done");
		@(posedge clk_in);
		rst_in <= 1'b1;
		waitc(2);
		oc(5'b00000);
		@(posedge clk_in);
		rst_in <= 1'b0;
		rchk(`UVS_ADDR_CTRL, 32'h0000_0000);
		$display("test reset done");
		wrap_up();
	end
endmodule
